// >>> verilog/trpc_cmd.sv
// Veil and unveil memory command engine with the feature control word
// Function
// RULE1: upper control byte holds permanent feature bits
// RULE2: indicator bits follow pads, never commands
// RULE3: temporary bits cleared at every power-up
// RULE4: permanent bits kept in non-volatile memory
// RULE5: veil success sets both hide flags
// RULE6: hidden banks withheld, all else unchanged
// RULE7: zero access password ignores veil command
// RULE8: reader prefixes frame-sync to both commands
// RULE9: reader keeps carrier up to 20 ms
// RULE10: veil reply: zero bit, handle, CRC
// RULE11: veiling takes effect after reply ends
// RULE12: internal failure sends error code instead
// RULE13: no reply in 20 ms means failure
// RULE14: replies always use extended pilot preamble
// RULE15: veil frame: code, handle, CRC-16
// RULE16: veil only from secured, else ignore/arbitrate
// RULE17: unveil success clears both hide flags
// RULE18: reader needs fresh Req_RN before unveil
// RULE19: unveil frame: code, covered password, handle, CRC
// RULE20: unveil from open/secured; bad password arbitrates
// RULE21: unveil reply: zero bit, handle, CRC
// RULE22: control word sits at code bank 200h
// RULE23: bad CRC frames ignored, state kept
module trpc_cmd import trpc_pkg::*; #(
  parameter int REPLY_LIMIT_CYC = TRPC_REPLY_LIMIT_CYC // Deadline for the reply
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset, power-up
  input trpc_rx_s rx, // Demodulated command bits
  input trpc_tag_e tag_state, // Air-interface state of the tag
  input wire logic [15:0] handle, // Current handle
  input wire logic [15:0] rn16, // Latest RN16 from Req_RN
  input wire logic rn_fresh, // Req_RN issued since last use
  input wire logic [31:0] access_pwd, // Stored access password
  output trpc_tx_s tx, // Reply bits
  input wire logic tx_ready, // Modulator takes the bit
  output logic err_req, // Pulse: send error code
  output logic go_arbitrate, // Pulse: move to arbitrate
  input wire logic [9:0] mem_addr, // Memory write bit address
  input wire logic mem_wr, // Memory write strobe
  input wire logic [15:0] mem_wdata, // Memory write data
  output logic [15:0] cfg_word, // Feature control word, read view
  input wire logic tamper_pad, // Tamper indicator input
  input wire logic ext_supply_pad, // External supply indicator input
  input wire logic nvm_load, // Pulse: stored byte valid
  input trpc_perm_s nvm_rdata, // Stored permanent byte
  output logic nvm_wr, // Pulse: program permanent byte
  output trpc_perm_s nvm_wdata, // Byte to program
  input wire logic nvm_done, // Pulse: programming finished
  input wire logic nvm_fail, // With done: programming failed
  output logic hide_code_read, // Withhold code bank contents
  output logic hide_id_read // Withhold identifier bank contents
);

  localparam logic [20:0] LIMIT_M1 = 21'(REPLY_LIMIT_CYC - 1);

  trpc_cmd_st_s q;
  trpc_cmd_st_s d;
  logic [15:0] rx_crc;
  logic crc_ok;
  logic is_veil;
  logic is_unveil;
  logic hdl_ok;
  logic pwd_ok;
  logic tx_take;
  logic tx_last;
  logic [15:0] reply_crc;

  // CRC over the whole received frame, restarted by frame-sync
  trpc_crc16 u_rx_crc (
    .clk(clk),
    .srst(srst),
    .init(rx.fsync),
    .en(rx.valid && q.st == ST_RECV && !rx.fsync),
    .din(rx.din),
    .crc(rx_crc)
  );

  // CRC over the reply header bit and handle
  function automatic logic [15:0] reply_crc_of(input logic [16:0] bits);
    logic [15:0] c;
    c = TRPC_CRC_PRESET;
    for (int i = 16; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ bits[i]) ? TRPC_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Frame decode; the handle always ends the frame just before the CRC
  always_comb begin
    crc_ok = (rx_crc == TRPC_CRC_RESIDUE); // RULE23
    is_veil = (q.cnt == TRPC_LEN_VEIL) && (q.sh[47:32] == TRPC_CODE_VEIL); // RULE15
    is_unveil = (q.cnt == TRPC_LEN_UNVEIL) && (q.sh[79:64] == TRPC_CODE_UNVEIL); // RULE19
    hdl_ok = (q.sh[31:16] == handle);
    pwd_ok = rn_fresh && ((q.sh[63:32] ^ {rn16, rn16}) == access_pwd); // RULE18
    tx_take = q.tx_valid && tx_ready;
    tx_last = q.tx_cnt == TRPC_LEN_REPLY - 6'h01;
    reply_crc = reply_crc_of({1'b0, handle});
  end

  // Next state of the whole engine
  always_comb begin
    d = q;
    d.err_req = 1'b0;
    d.arb = 1'b0;
    d.nvm_wr = 1'b0;
    d.ind = {ext_supply_pad, tamper_pad}; // RULE2
    // Memory writes reach only the temporary bits here
    if (mem_wr && mem_addr == TRPC_CFG_ADDR) begin // RULE22
      d.temp = {mem_wdata[TRPC_POS_DATA_MODE], mem_wdata[TRPC_POS_TRANSPARENT],
                mem_wdata[TRPC_POS_INVERT]};
    end
    // Stored byte arrives after power-up or after a memory write
    if (nvm_load && q.st != ST_PROG) begin // RULE4
      d.perm = nvm_rdata;
      d.veil_code = nvm_rdata.hide_code_bank_flag;
      d.veil_id = nvm_rdata.hide_identifier_bank_flag;
    end
    case (q.st)
      ST_IDLE: begin
        if (rx.fsync) begin // RULE8
          d.st = ST_RECV;
          d.cnt = 7'h00;
          d.sh = '0;
        end
      end
      ST_RECV: begin
        if (rx.fsync) begin
          d.cnt = 7'h00;
          d.sh = '0;
        end else if (rx.valid) begin
          d.sh = {q.sh[78:0], rx.din};
          if (q.cnt != TRPC_CNT_MAX) begin
            d.cnt = q.cnt + 7'h01;
          end
          if (rx.last) begin
            d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        d.st = ST_IDLE;
        d.pend = q.perm;
        d.wait_cnt = '0;
        if (crc_ok && is_veil && tag_state == TAG_SECURED && hdl_ok) begin // RULE16
          if (access_pwd != 32'h0000_0000) begin // RULE7
            d.pend.hide_code_bank_flag = 1'b1; // RULE5
            d.pend.hide_identifier_bank_flag = 1'b1;
            d.unveil = 1'b0;
            d.nvm_wr = 1'b1;
            d.st = ST_PROG;
          end
        end else if (crc_ok && is_unveil && hdl_ok &&
                     (tag_state == TAG_OPEN || tag_state == TAG_SECURED)) begin // RULE20
          if (pwd_ok) begin
            d.pend.hide_code_bank_flag = 1'b0; // RULE17
            d.pend.hide_identifier_bank_flag = 1'b0;
            d.unveil = 1'b1;
            d.nvm_wr = 1'b1;
            d.st = ST_PROG;
          end else begin
            d.arb = 1'b1;
          end
        end
      end
      ST_PROG: begin
        d.wait_cnt = q.wait_cnt + 21'h000001;
        if (nvm_done && !nvm_fail) begin
          d.perm = q.pend;
          if (q.unveil) begin // RULE17
            d.veil_code = 1'b0;
            d.veil_id = 1'b0;
          end
          d.tx_sh = {1'b0, handle, ~reply_crc}; // RULE10 RULE21
          d.tx_cnt = 6'h00;
          d.tx_valid = 1'b1;
          d.st = ST_SEND;
        end else if ((nvm_done && nvm_fail) || q.wait_cnt == LIMIT_M1) begin // RULE9
          d.err_req = 1'b1; // RULE12
          d.st = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (tx_take) begin
          d.tx_sh = {q.tx_sh[31:0], 1'b0};
          d.tx_cnt = q.tx_cnt + 6'h01;
          if (tx_last) begin
            d.tx_valid = 1'b0;
            d.st = ST_IDLE;
            if (!q.unveil) begin // RULE11
              d.veil_code = q.perm.hide_code_bank_flag;
              d.veil_id = q.perm.hide_identifier_bank_flag;
            end
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Read view of the whole control word
    d.cfg = '0;
    d.cfg[TRPC_POS_TAMPER] = q.ind[0];
    d.cfg[TRPC_POS_EXT_SUPPLY] = q.ind[1];
    d.cfg[TRPC_POS_INVERT] = q.temp[0];
    d.cfg[TRPC_POS_TRANSPARENT] = q.temp[1];
    d.cfg[TRPC_POS_DATA_MODE] = q.temp[2];
    d.cfg[TRPC_PERM_LSB +: 8] = q.perm; // RULE1
  end

  // State register; permanent byte reloads from the array after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      q.st <= ST_IDLE;
      q.sh <= '0;
      q.cnt <= 7'h00;
      q.unveil <= 1'b0;
      q.perm <= '0;
      q.pend <= '0;
      q.temp <= TRPC_TEMP_RESET; // RULE3
      q.ind <= 2'h0;
      q.veil_code <= 1'b0;
      q.veil_id <= 1'b0;
      q.tx_sh <= '0;
      q.tx_cnt <= 6'h00;
      q.tx_valid <= 1'b0;
      q.err_req <= 1'b0;
      q.arb <= 1'b0;
      q.nvm_wr <= 1'b0;
      q.wait_cnt <= '0;
      q.cfg <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign tx = '{valid: q.tx_valid, dbit: q.tx_sh[32], ext_preamble: q.tx_valid}; // RULE14
  assign err_req = q.err_req;
  assign go_arbitrate = q.arb;
  assign cfg_word = q.cfg;
  assign nvm_wr = q.nvm_wr;
  assign nvm_wdata = q.pend;
  assign hide_code_read = q.veil_code; // RULE6
  assign hide_id_read = q.veil_id;

  // Reply in progress: the last bit is taken by the modulator
  sequence s_reply_end;
    q.st == ST_SEND && tx_take && tx_last;
  endsequence

  chk_reply_preamble: assert property (@(posedge clk) disable iff (srst) // RULE14
    tx.valid |-> tx.ext_preamble)
    else $error("reply bit without extended preamble");

  chk_reply_header: assert property (@(posedge clk) disable iff (srst) // RULE10
    $rose(tx.valid) |-> !tx.dbit && q.tx_cnt == 6'h00)
    else $error("reply does not open with a zero header bit");

  chk_veil_sets_flags: assert property (@(posedge clk) disable iff (srst) // RULE5
    (q.st == ST_PROG && nvm_done && !nvm_fail && !q.unveil) |=>
      q.perm.hide_code_bank_flag && q.perm.hide_identifier_bank_flag)
    else $error("veil success did not set both hide flags");

  chk_veil_after_reply: assert property (@(posedge clk) disable iff (srst) // RULE11
    (s_reply_end and !q.unveil) |=> hide_code_read && hide_id_read)
    else $error("veil not applied right after the reply");

  chk_veil_not_early: assert property (@(posedge clk) disable iff (srst) // RULE11
    (q.st == ST_SEND && !(tx_take && tx_last) && !nvm_load) |=> $stable(hide_code_read))
    else $error("veil changed while the reply was still going");

  chk_zero_pwd_ignored: assert property (@(posedge clk) disable iff (srst) // RULE7
    (q.st == ST_EXEC && is_veil && access_pwd == 32'h0000_0000) |=>
      q.st == ST_IDLE && !nvm_wr && !go_arbitrate ##1 !tx.valid)
    else $error("veil acted on a zero access password");

  chk_bad_crc_ignored: assert property (@(posedge clk) disable iff (srst) // RULE23
    (q.st == ST_EXEC && !crc_ok) |=> q.st == ST_IDLE && !nvm_wr && !go_arbitrate)
    else $error("frame with bad CRC was acted on");

  chk_unveil_bad_pwd: assert property (@(posedge clk) disable iff (srst) // RULE20
    (q.st == ST_EXEC && crc_ok && is_unveil && hdl_ok && !pwd_ok &&
     (tag_state == TAG_OPEN || tag_state == TAG_SECURED)) |=> go_arbitrate ##1 !go_arbitrate)
    else $error("unveil with wrong password did not arbitrate once");

  chk_fail_error: assert property (@(posedge clk) disable iff (srst) // RULE12
    (q.st == ST_PROG && nvm_done && nvm_fail) |=> err_req && !tx.valid)
    else $error("programming failure did not request an error code");

  // Pads reach the read view two cycles late; skip the edges right after reset
  chk_indicator_track: assert property (@(posedge clk) disable iff (srst) // RULE2
    !srst ##1 !srst |=> cfg_word[TRPC_POS_TAMPER] == $past(tamper_pad, 2))
    else $error("tamper indicator not following its pad");

  chk_supply_track: assert property (@(posedge clk) disable iff (srst) // RULE2
    !srst ##1 !srst |=> cfg_word[TRPC_POS_EXT_SUPPLY] == $past(ext_supply_pad, 2))
    else $error("supply indicator not following its pad");

  // Command outcomes one edge after the decode, the programming result or the deadline; reply length checked in its own cycle, temporary bits after reset
  chk_unveil_clears: assert property (@(posedge clk) disable iff (srst) // RULE17
    (q.st == ST_PROG && nvm_done && !nvm_fail && q.unveil) |=>
      !hide_code_read && !hide_id_read && !q.perm.hide_code_bank_flag)
    else $error("unveil success did not clear the hide flags");

  chk_reply_length: assert property (@(posedge clk) disable iff (srst) // RULE10
    q.st == ST_SEND |-> q.tx_cnt < TRPC_LEN_REPLY)
    else $error("reply longer than header, handle and CRC");

  chk_reply_handle: assert property (@(posedge clk) disable iff (srst) // RULE21
    (q.st == ST_PROG && nvm_done && !nvm_fail) |=> !q.tx_sh[32] && q.tx_sh[31:16] == $past(handle))
    else $error("reply does not carry the handle");

  chk_prog_timeout: assert property (@(posedge clk) disable iff (srst) // RULE12
    (q.st == ST_PROG && !nvm_done && q.wait_cnt == LIMIT_M1) |=> err_req && q.st == ST_IDLE)
    else $error("stuck programming did not request an error code");

  chk_veil_bad_handle: assert property (@(posedge clk) disable iff (srst) // RULE16
    (q.st == ST_EXEC && is_veil && !hdl_ok) |=> !nvm_wr && !go_arbitrate)
    else $error("veil with wrong handle was acted on");

  chk_veil_not_secured: assert property (@(posedge clk) disable iff (srst) // RULE16
    (q.st == ST_EXEC && is_veil && tag_state != TAG_SECURED) |=> !nvm_wr && !go_arbitrate)
    else $error("veil outside the secured state was acted on");

  chk_unveil_accept: assert property (@(posedge clk) disable iff (srst) // RULE20
    (q.st == ST_EXEC && crc_ok && is_unveil && hdl_ok && pwd_ok &&
     (tag_state == TAG_OPEN || tag_state == TAG_SECURED)) |=> nvm_wr && !go_arbitrate)
    else $error("valid unveil did not start programming");

  chk_temp_cleared: assert property (@(posedge clk) // RULE3
    $past(srst) |-> q.temp == TRPC_TEMP_RESET)
    else $error("temporary bits not cleared at power-up");

endmodule

// >>> verilog/trpc_pkg.sv
// Package: constants, states and carriers of the read-protect command block
package trpc_pkg;

  // Command codes and frame lengths in bits
  localparam logic [15:0] TRPC_CODE_VEIL = 16'he001;
  localparam logic [15:0] TRPC_CODE_UNVEIL = 16'he002;
  localparam logic [6:0] TRPC_LEN_VEIL = 7'h30;
  localparam logic [6:0] TRPC_LEN_UNVEIL = 7'h50;
  localparam logic [6:0] TRPC_CNT_MAX = 7'h7f;
  localparam logic [5:0] TRPC_LEN_REPLY = 6'h21;

  // CRC-16 of the air interface
  localparam logic [15:0] TRPC_CRC_POLY = 16'h1021;
  localparam logic [15:0] TRPC_CRC_PRESET = 16'hffff;
  localparam logic [15:0] TRPC_CRC_RESIDUE = 16'h1d0f;

  // Feature control word location (bit address in the code bank)
  localparam logic [9:0] TRPC_CFG_ADDR = 10'h200;
  localparam logic [9:0] TRPC_PERM_ADDR = 10'h208;

  // Field positions of the lower (indicator and temporary) byte
  localparam int TRPC_POS_TAMPER = 0;
  localparam int TRPC_POS_EXT_SUPPLY = 1;
  localparam int TRPC_POS_INVERT = 4;
  localparam int TRPC_POS_TRANSPARENT = 5;
  localparam int TRPC_POS_DATA_MODE = 6;
  localparam int TRPC_PERM_LSB = 8;
  localparam logic [2:0] TRPC_TEMP_RESET = 3'h0;

  // Reply deadline: time in ms and derived count at the clock rate
  localparam int TRPC_CLK_HZ = 100000000;
  localparam int TRPC_REPLY_LIMIT_MS = 20;
  localparam int TRPC_REPLY_LIMIT_CYC = TRPC_REPLY_LIMIT_MS * (TRPC_CLK_HZ / 1000);

  // Air-interface states of the surrounding tag
  typedef enum logic [2:0] {
    TAG_READY = 3'h0,
    TAG_ARBITRATE = 3'h1,
    TAG_REPLY = 3'h2,
    TAG_ACKNOWLEDGED = 3'h3,
    TAG_OPEN = 3'h4,
    TAG_SECURED = 3'h5,
    TAG_KILLED = 3'h6
  } trpc_tag_e;

  // Command engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_PROG = 5'b01000,
    ST_SEND = 5'b10000
  } trpc_state_e;

  // Permanent byte, bit 15 down to bit 8
  typedef struct packed {
    logic surveillance_alarm_flag;
    logic hide_identifier_bank_flag;
    logic hide_code_bank_flag;
    logic reserved_bit_12;
    logic privacy_mode;
    logic digital_output;
    logic max_backscatter;
    logic reserved_bit_8;
  } trpc_perm_s;

  // Received command bits from the demodulator
  typedef struct packed {
    logic fsync;
    logic valid;
    logic din;
    logic last;
  } trpc_rx_s;

  // Reply bits to the modulator
  typedef struct packed {
    logic valid;
    logic dbit;
    logic ext_preamble;
  } trpc_tx_s;

  // State of the serial CRC
  typedef struct packed {
    logic [15:0] crc;
  } trpc_crc_st_s;

  // State of the command engine
  typedef struct packed {
    trpc_state_e st;
    logic [79:0] sh;
    logic [6:0] cnt;
    logic unveil;
    trpc_perm_s perm;
    trpc_perm_s pend;
    logic [2:0] temp;
    logic [1:0] ind;
    logic veil_code;
    logic veil_id;
    logic [32:0] tx_sh;
    logic [5:0] tx_cnt;
    logic tx_valid;
    logic err_req;
    logic arb;
    logic nvm_wr;
    logic [20:0] wait_cnt;
    logic [15:0] cfg;
  } trpc_cmd_st_s;

endpackage

// >>> verilog/trpc_crc16.sv
// Serial CRC-16 register, one bit per enable
module trpc_crc16 import trpc_pkg::*; (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic init, // Load preset
  input wire logic en, // Shift in one bit
  input wire logic din, // Bit to shift in
  output logic [15:0] crc // Current register
);

  trpc_crc_st_s q;
  trpc_crc_st_s d;

  // Next value: preset wins over shifting
  always_comb begin
    d = q;
    if (init) begin
      d.crc = TRPC_CRC_PRESET;
    end else if (en) begin
      d.crc = {q.crc[14:0], 1'b0} ^ ((q.crc[15] ^ din) ? TRPC_CRC_POLY : 16'h0000);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q.crc <= TRPC_CRC_PRESET;
    end else begin
      q <= d;
    end
  end

  assign crc = q.crc;

endmodule

// >>> bench/trpc_reader.sv
// Interrogator model: sends command frames and takes reply bits
module trpc_reader import trpc_pkg::*; (
  input wire logic clk, // System clock
  output trpc_rx_s rx, // Command bits to the tag
  input trpc_tx_s tx, // Reply bits from the tag
  output logic tx_ready, // Takes reply bits
  output logic [32:0] got, // Captured reply
  output logic [5:0] n_got // Reply bits taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  initial begin
    rx = '0;
    tx_ready = 1'b0;
    got = '0;
    n_got = '0;
  end
  // Air CRC-16, preset ffff, sent complemented
  function automatic logic [15:0] crc16(input logic [79:0] d, input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return ~c;
  endfunction
  // Frame-sync, then the bits first to last; line shows the inverse after
  task automatic send(input logic [79:0] f, input int n);
    @(posedge clk);
    rx <= '{fsync: 1'b1, valid: 1'b0, din: 1'b0, last: 1'b0};
    n_got <= '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      rx <= '{fsync: 1'b0, valid: 1'b1, din: f[i], last: i == 0};
    end
    @(posedge clk);
    rx <= '{fsync: 1'b0, valid: 1'b0, din: ~f[0], last: 1'b0};
  endtask
  // Carrier stays up; reply taken promptly or every other cycle
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx.valid && tx_ready) begin
      got <= {got[31:0], tx.dbit};
      n_got <= n_got + 6'h01;
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench of the read-protect command engine
module tb_top import trpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  trpc_rx_s rx;
  trpc_tx_s tx;
  trpc_tag_e tag_state = TAG_SECURED;
  logic tx_ready, err_req, go_arb, nvm_wr, hide_c, hide_i;
  logic nvm_load = 1'b0, rn_fresh = 1'b0, mem_wr = 1'b0, tamper = 1'b0;
  logic ext_sup = 1'b0, nvm_done = 1'b0, nvm_fail = 1'b0;
  logic [15:0] handle = 16'h5a3c, rn16 = 16'h1234, mem_wdata = '0, cfg_word;
  logic [31:0] pwd = 32'hc0de1234;
  logic [9:0] mem_addr = '0;
  trpc_perm_s nvm_rdata = '0, nv_store = '0, nvm_wdata;
  logic [32:0] got;
  logic [5:0] n_got;
  int n_mismatch = 0, checks_done = 0, n_ev = 0, nvm_mode = 0;

  always #5 clk = ~clk;

  trpc_cmd #(.REPLY_LIMIT_CYC(200)) trpc_cmd_inst (.clk(clk), .srst(srst), .rx(rx),
    .tag_state(tag_state), .handle(handle), .rn16(rn16), .rn_fresh(rn_fresh),
    .access_pwd(pwd), .tx(tx), .tx_ready(tx_ready), .err_req(err_req),
    .go_arbitrate(go_arb), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .cfg_word(cfg_word), .tamper_pad(tamper), .ext_supply_pad(ext_sup),
    .nvm_load(nvm_load), .nvm_rdata(nvm_rdata), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .hide_code_read(hide_c),
    .hide_id_read(hide_i));
  trpc_reader trpc_reader_inst (.clk(clk), .rx(rx), .tx(tx), .tx_ready(tx_ready),
    .got(got), .n_got(n_got));

  // Store model: done a cycle after program, fail or hang on demand; event count
  always @(posedge clk) begin
    nvm_done <= nvm_wr && nvm_mode != 2;
    nvm_fail <= nvm_wr && nvm_mode == 1;
    if (nvm_wr && nvm_mode == 0) nv_store <= nvm_wdata;
    if (tx.valid || go_arb || nvm_wr || err_req) n_ev <= n_ev + 1;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Power cycle: reset, then recall of the stored byte
  task automatic powerup(input trpc_perm_s p);
    @(posedge clk) srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    nvm_rdata <= p;
    nvm_load <= 1'b1;
    @(posedge clk) nvm_load <= 1'b0;
    nv_store <= p;
    cyc(3);
  endtask

  function automatic logic [79:0] veil_f(input logic [15:0] h);
    return {32'h0, 16'he001, h, trpc_reader_inst.crc16({48'h0, 16'he001, h}, 32)};
  endfunction

  function automatic logic [79:0] unveil_f(input logic [31:0] p, input logic [15:0] h);
    logic [63:0] b;
    b = {16'he002, p ^ {rn16, rn16}, h};
    return {b, trpc_reader_inst.crc16({16'h0, b}, 64)};
  endfunction

  task automatic wait_reply(input logic [15:0] h);
    int k;
    k = 0;
    while (n_got !== 6'h21 && k < 2000) begin
      cyc(1);
      k++;
    end
    chk(got, {1'b0, h, trpc_reader_inst.crc16({63'h0, h}, 17)}, "reply");
  endtask

  task automatic t_cfg();
    chk(cfg_word, 16'h0600, "power-up view");
    @(posedge clk);
    tamper <= 1'b1;
    mem_addr <= 10'h200;
    mem_wdata <= 16'h0073;
    mem_wr <= 1'b1;
    @(posedge clk) mem_wr <= 1'b0;
    cyc(3);
    chk(cfg_word[7:0], 8'h71, "low byte after write");
    powerup(trpc_perm_s'(8'h06));
    chk(cfg_word, 16'h0601, "view after power cycle");
  endtask

  task automatic t_veil();
    int k;
    k = 0;
    trpc_reader_inst.slow <= 1'b1;
    trpc_reader_inst.send(veil_f(handle), 48);
    while (tx.valid !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    chk(tx.ext_preamble, 1'b1, "no pilot preamble");
    chk({hide_i, hide_c}, 2'h0, "hidden before reply");
    wait_reply(handle);
    cyc(2);
    chk({hide_i, hide_c, cfg_word[15:13]}, 5'h1b, "flags after veil");
    chk(nv_store, trpc_perm_s'(8'h66), "stored byte after veil");
  endtask

  // Open state, zero password, bad CRC, wrong handle
  task automatic t_ignore();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tag_state <= i == 0 ? TAG_OPEN : TAG_SECURED;
      pwd <= i == 1 ? 32'h0 : 32'hc0de1234;
      n_ev <= 0;
      trpc_reader_inst.send(veil_f(handle ^ 16'(i == 3)) ^ 80'(i == 2), 48);
      cyc(300);
      chk(n_ev, 0, "ignored veil reacted");
    end
  endtask

  // Stale RN16, wrong password, then success from open
  task automatic t_unveil();
    trpc_reader_inst.slow <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      tag_state <= i == 2 ? TAG_OPEN : TAG_SECURED;
      rn_fresh <= i != 0;
      n_ev <= 0;
      trpc_reader_inst.send(unveil_f(i == 1 ? pwd ^ 32'h1 : pwd, handle), 80);
      if (i < 2) begin
        cyc(20);
        chk({n_ev, go_arb}, {32'h1, 1'b0}, "bad unveil not one pulse");
        chk({hide_i, hide_c}, 2'h3, "flags lost");
      end
    end
    wait_reply(handle);
    cyc(2);
    chk({hide_i, hide_c, cfg_word[14:13]}, 4'h0, "flags after unveil");
    chk(nv_store, trpc_perm_s'(8'h06), "stored byte after unveil");
  endtask

  // Store failure, then store hang
  task automatic t_err();
    int k;
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      nvm_mode <= m;
      tag_state <= TAG_SECURED;
      trpc_reader_inst.send(veil_f(handle), 48);
      k = 0;
      while (err_req !== 1'b1 && k < 400) begin
        cyc(1);
        k++;
      end
      chk(err_req, 1'b1, "no error pulse");
      cyc(5);
      chk(n_got, 6'h00, "reply on failure");
    end
    nvm_mode <= 0;
  endtask

  // Main sequence
  initial begin
    powerup(trpc_perm_s'(8'h06));
    t_cfg();
    $display("cfg test ended");
    t_veil();
    $display("veil test ended");
    t_ignore();
    $display("ignore test ended");
    t_unveil();
    $display("unveil test ended");
    t_err();
    $display("error test ended");
    test_done();
  end

  // Watchdog
  initial begin
    #500us;
    n_mismatch++;
    $display("mismatch at %0t: watchdog", $time);
    test_done();
  end
endmodule
